// ### rtl/trap_core.sv
// trap, transfer, test and wait execution core with an apb control port
`timescale 1ns/1ns
`default_nettype none
`include "trap_core_map.svh"
module trap_core #(
  parameter logic [15:0] TRAP_VECTOR = 16'hfffc, // vector high byte address, low at +1
  parameter logic [15:0] IRQ_VECTOR = 16'hfffa
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output trap_core_pkg::mem_req_t o_mem,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_irq,
  output logic o_cpu_halted
);
  // ****************************************
  // state
  // ****************************************
  trap_core_pkg::state_t state_r, state_nxt;
  trap_core_pkg::decode_t dec_now; // decode of the byte on the bus
  trap_core_pkg::decode_t dec_r; // decode of the running opcode
  trap_core_pkg::flags_t condition_flags_reg_r;
  trap_core_pkg::mem_req_t mem_req;
  logic [15:0] pc_r;
  logic [15:0] ea_r; // operand address
  logic [7:0] hi_r; // first of two operand bytes
  logic [7:0] acc_r;
  logic [7:0] index_r;
  logic [7:0] stack_ptr_r;
  logic [2:0] push_idx_r;
  logic [3:0] cyc_r; // cycle number within the instruction
  logic [3:0] total_r;
  logic vec_irq_r; // vector select: trap or interrupt
  logic run_r;
  logic fetch_go;
  logic resume;
  logic apb_wr;
  logic mapped;
  logic [15:0] vec_addr;

  assign fetch_go = (state_r == trap_core_pkg::st_fetch) && run_r;
  assign vec_addr = vec_irq_r ? IRQ_VECTOR : TRAP_VECTOR;
  assign o_mem = mem_req;
  assign o_cpu_halted = (state_r == trap_core_pkg::st_wait);

  trap_opcode_decode u_dec (
    .i_opcode(i_mem_rdata),
    .o_dec(dec_now)
  );

  // n and z from a value, the rest kept
  function automatic trap_core_pkg::flags_t test_flags(input trap_core_pkg::flags_t f,
                                                       input logic [7:0] v);
    trap_core_pkg::flags_t r;
    r = f;
    r.n = v[7];
    r.z = (v == 8'h00);
    return r;
  endfunction

  // ****************************************
  // sequencer and memory request
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    mem_req.addr = pc_r;
    mem_req.we = 1'b0;
    mem_req.wdata = 8'h00;
    unique case (state_r)
      trap_core_pkg::st_fetch: begin
        if (run_r) begin
          if (dec_now.op == trap_core_pkg::software_trap_op) begin
            state_nxt = trap_core_pkg::st_push;
          end else if (dec_now.op == trap_core_pkg::other_op &&
                       dec_now.mode == trap_core_pkg::inherent_mode) begin
            state_nxt = trap_core_pkg::st_halt; // nothing to execute here
          end else if (dec_now.mode == trap_core_pkg::inherent_mode) begin
            state_nxt = trap_core_pkg::st_pad;
          end else if (dec_now.mode == trap_core_pkg::indexed_no_offset_mode) begin
            state_nxt = (dec_now.op == trap_core_pkg::test_operand_op) ?
                        trap_core_pkg::st_read : trap_core_pkg::st_halt;
          end else begin
            state_nxt = trap_core_pkg::st_opnd1;
          end
        end
      end
      trap_core_pkg::st_opnd1: begin
        // two-byte modes take a second byte
        if (dec_r.mode == trap_core_pkg::extended_mode ||
            dec_r.mode == trap_core_pkg::indexed_long_offset_mode) begin
          state_nxt = trap_core_pkg::st_opnd2;
        end else begin
          state_nxt = (dec_r.op == trap_core_pkg::test_operand_op) ?
                      trap_core_pkg::st_read : trap_core_pkg::st_halt;
        end
      end
      trap_core_pkg::st_opnd2: begin
        state_nxt = (dec_r.op == trap_core_pkg::test_operand_op) ?
                    trap_core_pkg::st_read : trap_core_pkg::st_halt;
      end
      trap_core_pkg::st_read: begin
        mem_req.addr = ea_r; // read only, never written back
        state_nxt = trap_core_pkg::st_pad;
      end
      trap_core_pkg::st_push: begin
        mem_req.addr = {8'h00, stack_ptr_r};
        mem_req.we = 1'b1;
        // stacking order low pc, high pc, index, acc, flags
        unique case (push_idx_r)
          3'h0: mem_req.wdata = pc_r[7:0];
          3'h1: mem_req.wdata = pc_r[15:8];
          3'h2: mem_req.wdata = index_r;
          3'h3: mem_req.wdata = acc_r;
          default: mem_req.wdata = condition_flags_reg_r;
        endcase
        if (push_idx_r == `PUSH_LAST) begin
          state_nxt = trap_core_pkg::st_vech;
        end
      end
      trap_core_pkg::st_vech: begin
        mem_req.addr = vec_addr;
        state_nxt = trap_core_pkg::st_vecl;
      end
      trap_core_pkg::st_vecl: begin
        mem_req.addr = vec_addr + 16'h0001;
        state_nxt = trap_core_pkg::st_pad;
      end
      trap_core_pkg::st_pad: begin
        // idle cycles pad out the required count
        if (cyc_r >= total_r) begin
          state_nxt = (dec_r.op == trap_core_pkg::wait_op) ?
                      trap_core_pkg::st_wait : trap_core_pkg::st_fetch;
        end
      end
      trap_core_pkg::st_wait: begin
        // clock held until an unmasked interrupt
        if (i_irq && !condition_flags_reg_r.i) begin
          state_nxt = trap_core_pkg::st_push;
        end
      end
      trap_core_pkg::st_halt: begin
        if (resume) begin
          state_nxt = trap_core_pkg::st_fetch;
        end
      end
      default: state_nxt = trap_core_pkg::st_halt; // illegal one-hot code
    endcase
  end

  // state, cycle count and latched decode
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= trap_core_pkg::st_fetch;
      cyc_r <= 4'h0;
      total_r <= 4'h0;
      dec_r <= '0;
      vec_irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (fetch_go) begin
        cyc_r <= 4'h2;
        total_r <= dec_now.cycles;
        dec_r <= dec_now;
        vec_irq_r <= 1'b0;
      end else if (state_r == trap_core_pkg::st_wait &&
                   state_nxt == trap_core_pkg::st_push) begin
        cyc_r <= 4'h2; // wake runs the trap stacking sequence
        total_r <= `CYC_TRAP;
        dec_r.op <= trap_core_pkg::software_trap_op;
        vec_irq_r <= 1'b1;
      end else if (cyc_r != 4'hf) begin
        cyc_r <= cyc_r + 4'h1;
      end
    end
  end

  // program counter and operand address
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_r <= `PC_RESET;
      ea_r <= 16'h0000;
      hi_r <= 8'h00;
    end else begin
      unique case (state_r)
        trap_core_pkg::st_fetch: begin
          if (run_r) begin
            pc_r <= pc_r + 16'h0001; // pc advanced before stacking
            ea_r <= {8'h00, index_r};
          end
        end
        trap_core_pkg::st_opnd1: begin
          pc_r <= pc_r + 16'h0001;
          hi_r <= i_mem_rdata;
          if (dec_r.mode == trap_core_pkg::indexed_short_offset_mode) begin
            ea_r <= {8'h00, i_mem_rdata} + {8'h00, index_r};
          end else begin
            ea_r <= {8'h00, i_mem_rdata}; // direct page address
          end
        end
        trap_core_pkg::st_opnd2: begin
          pc_r <= pc_r + 16'h0001;
          if (dec_r.mode == trap_core_pkg::indexed_long_offset_mode) begin
            ea_r <= {hi_r, i_mem_rdata} + {8'h00, index_r};
          end else begin
            ea_r <= {hi_r, i_mem_rdata}; // high byte first
          end
        end
        trap_core_pkg::st_vech: pc_r[15:8] <= i_mem_rdata;
        trap_core_pkg::st_vecl: pc_r[7:0] <= i_mem_rdata;
        default: begin
        end
      endcase
    end
  end

  // accumulator, index and flags
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_r <= 8'h00;
      index_r <= 8'h00;
      condition_flags_reg_r <= `FLAGS_RESET;
    end else if (fetch_go) begin
      unique case (dec_now.op)
        trap_core_pkg::acc_to_index_op: index_r <= acc_r; // flags kept
        trap_core_pkg::index_to_acc_op: acc_r <= index_r; // flags kept
        trap_core_pkg::wait_op: condition_flags_reg_r.i <= 1'b0;
        trap_core_pkg::test_operand_op: begin
          if (dec_now.mode == trap_core_pkg::inherent_mode) begin
            condition_flags_reg_r <= test_flags(condition_flags_reg_r,
                                                dec_now.src_index ? index_r : acc_r);
          end
        end
        default: begin
        end
      endcase
    end else if (state_r == trap_core_pkg::st_read) begin
      condition_flags_reg_r <= test_flags(condition_flags_reg_r, i_mem_rdata);
    end else if (state_r == trap_core_pkg::st_vech) begin
      condition_flags_reg_r.i <= 1'b1; // mask set once stacked
    end
  end

  // stack pointer, post-decrement after each push
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stack_ptr_r <= `STACK_RESET;
      push_idx_r <= 3'h0;
    end else if (state_r == trap_core_pkg::st_push) begin
      stack_ptr_r <= stack_ptr_r - 8'h01;
      push_idx_r <= push_idx_r + 3'h1;
    end else begin
      push_idx_r <= 3'h0;
    end
  end

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  assign o_pready = 1'b1;
  assign mapped = (i_paddr == `OFS_CTRL) || (i_paddr == `OFS_STATUS) ||
                  (i_paddr == `OFS_REGS) || (i_paddr == `OFS_ADDR);
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign apb_wr = i_psel && i_penable && i_pwrite && (i_paddr == `OFS_CTRL);
  assign resume = apb_wr && i_pwdata[`CTRL_RESUME_BIT];

  // control register: run gate for fetch
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_r <= `RUN_RESET;
    end else if (apb_wr) begin
      run_r <= i_pwdata[`CTRL_RUN_BIT];
    end
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      unique case (i_paddr)
        `OFS_CTRL: o_prdata <= {31'h0000_0000, run_r};
        `OFS_STATUS: o_prdata <= {29'h0000_0000, run_r,
                                  state_r == trap_core_pkg::st_halt,
                                  state_r == trap_core_pkg::st_wait};
        `OFS_REGS: o_prdata <= {condition_flags_reg_r, stack_ptr_r, index_r, acc_r};
        `OFS_ADDR: o_prdata <= {ea_r, pc_r};
        default: o_prdata <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_TRAP_STACK: assert property (fetch_go && i_mem_rdata == `OP_TRAP |=>
    (o_mem.we && o_mem.wdata == pc_r[7:0]) ##1
    (o_mem.we && o_mem.wdata == pc_r[15:8] && o_mem.addr == $past(o_mem.addr) - 16'h0001)
    ##1 (o_mem.we && o_mem.wdata == index_r) ##1 (o_mem.we && o_mem.wdata == acc_r))
    else $error("trap stacking order wrong");
  AST_TRAP_LEN: assert property (fetch_go && i_mem_rdata == `OP_TRAP |->
    ##1 (state_r != trap_core_pkg::st_fetch) [*8] ##1 (state_r != trap_core_pkg::st_fetch)
    ##1 (state_r == trap_core_pkg::st_fetch))
    else $error("trap did not take ten cycles");
  AST_TRAP_MASK: assert property (state_r == trap_core_pkg::st_vecl |=>
    condition_flags_reg_r.i && pc_r == {$past(pc_r[15:8]), $past(i_mem_rdata)} &&
    condition_flags_reg_r.n == $past(condition_flags_reg_r.n, 2) &&
    condition_flags_reg_r.c == $past(condition_flags_reg_r.c, 2))
    else $error("trap vector or mask wrong");
  AST_A2X: assert property (fetch_go && i_mem_rdata == `OP_A2X |=>
    index_r == $past(acc_r) && condition_flags_reg_r == $past(condition_flags_reg_r)
    ##1 state_r == trap_core_pkg::st_fetch)
    else $error("acc to index transfer wrong");
  AST_X2A: assert property (fetch_go && i_mem_rdata == `OP_X2A |=>
    acc_r == $past(index_r) && condition_flags_reg_r == $past(condition_flags_reg_r)
    ##1 state_r == trap_core_pkg::st_fetch)
    else $error("index to acc transfer wrong");
  AST_TEST_FLAGS: assert property (state_r == trap_core_pkg::st_read |-> !o_mem.we ##1
    condition_flags_reg_r.n == $past(i_mem_rdata[7]) &&
    condition_flags_reg_r.z == ($past(i_mem_rdata) == 8'h00) &&
    condition_flags_reg_r.h == $past(condition_flags_reg_r.h) &&
    condition_flags_reg_r.c == $past(condition_flags_reg_r.c))
    else $error("test flags wrong");
  AST_TEST_SHORT_LEN: assert property (fetch_go && i_mem_rdata == `OP_TEST_SHORT |->
    ##4 state_r == trap_core_pkg::st_pad ##1 state_r == trap_core_pkg::st_fetch)
    else $error("short indexed test length wrong");
  AST_TEST_DIR_LEN: assert property (fetch_go && i_mem_rdata == `OP_TEST_DIR |->
    ##3 state_r == trap_core_pkg::st_pad ##1 state_r == trap_core_pkg::st_fetch)
    else $error("direct test length wrong");
  AST_WAIT_ENTRY: assert property (fetch_go && i_mem_rdata == `OP_WAIT |=>
    !condition_flags_reg_r.i ##1 o_cpu_halted)
    else $error("wait did not halt with mask clear");
  AST_LONG_EA: assert property (state_r == trap_core_pkg::st_opnd2 &&
    dec_r.mode == trap_core_pkg::indexed_long_offset_mode |=>
    ea_r == {$past(hi_r), $past(i_mem_rdata)} + {8'h00, $past(index_r)})
    else $error("long offset address wrong");
  AST_EXTENDED_EA: assert property (state_r == trap_core_pkg::st_opnd2 &&
    dec_r.mode == trap_core_pkg::extended_mode |=>
    ea_r == {$past(hi_r), $past(i_mem_rdata)} && pc_r == $past(pc_r) + 16'h0001)
    else $error("extended address wrong");
  AST_WAKE: assert property (o_cpu_halted && i_irq |=>
    state_r == trap_core_pkg::st_push ##5 o_mem.addr == IRQ_VECTOR)
    else $error("wake did not take interrupt vector");

  COV_TRAP: cover property (state_r == trap_core_pkg::st_vecl ##1 state_r == trap_core_pkg::st_pad);
  COV_WAKE: cover property (o_cpu_halted ##1 state_r == trap_core_pkg::st_push);
  COV_TEST_SHORT: cover property (fetch_go && i_mem_rdata == `OP_TEST_SHORT);
  COV_XFER: cover property (fetch_go && i_mem_rdata == `OP_A2X);
endmodule
`default_nettype wire

// ### rtl/trap_core_map.svh
// offsets, field positions, reset values, opcodes and cycle counts of the trap core
`ifndef TRAP_CORE_MAP_SVH
`define TRAP_CORE_MAP_SVH
// Overview of operation
// - trap advances pc, pushes pc, index, acc, flags
// - trap sets mask, loads PC from vector
// - 97 copies A into X, flags kept
// - test sets N and Z only, no write
// - 9F copies X into A, flags kept
// - 8F clears mask and halts processor clock
// - short offset one byte; long high then low
// - extended address high then low; direct one
// ****************************************
// apb register offsets and fields
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_REGS 12'h008
`define OFS_ADDR 12'h00c
`define CTRL_RUN_BIT 0
`define CTRL_RESUME_BIT 1
`define STAT_WAIT_BIT 0
`define STAT_HALT_BIT 1
`define STAT_RUN_BIT 2
// ****************************************
// reset values
// ****************************************
`define RUN_RESET 1'b0
`define STACK_RESET 8'hff
`define FLAGS_RESET 8'he8
`define PC_RESET 16'h0000
// ****************************************
// opcodes and cycle counts
// ****************************************
`define OP_TRAP 8'h83
`define OP_A2X 8'h97
`define OP_X2A 8'h9f
`define OP_WAIT 8'h8f
`define OP_TEST_DIR 8'h3d
`define OP_TEST_SHORT 8'h6d
`define CYC_TRAP 4'ha
`define CYC_XFER 4'h2
`define CYC_WAIT 4'h2
`define CYC_TEST_DIR 4'h4
`define CYC_TEST_REG 4'h3
`define CYC_TEST_SHORT 4'h5
`define CYC_TEST_NOOFS 4'h4
`define PUSH_LAST 3'h4
`endif

// ### rtl/trap_core_pkg.sv
// types shared by the trap core and its opcode decoder
package trap_core_pkg;
  // one-hot sequencer states
  typedef enum logic [9:0] {
    st_fetch = 10'h001,
    st_opnd1 = 10'h002,
    st_opnd2 = 10'h004,
    st_read = 10'h008,
    st_push = 10'h010,
    st_vech = 10'h020,
    st_vecl = 10'h040,
    st_pad = 10'h080,
    st_wait = 10'h100,
    st_halt = 10'h200
  } state_t;
  typedef enum logic [2:0] {
    inherent_mode,
    direct_mode,
    extended_mode,
    indexed_long_offset_mode,
    indexed_short_offset_mode,
    indexed_no_offset_mode
  } addr_mode_t;
  typedef enum logic [2:0] {
    software_trap_op,
    acc_to_index_op,
    index_to_acc_op,
    test_operand_op,
    wait_op,
    other_op
  } op_kind_t;
  // flags byte: three ones above h i n z c
  typedef struct packed {
    logic [2:0] ones;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } flags_t;
  typedef struct packed {
    logic [15:0] addr;
    logic we;
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    addr_mode_t mode;
    op_kind_t op;
    logic src_index;
    logic [3:0] cycles;
  } decode_t;
endpackage

// ### rtl/trap_opcode_decode.sv
// opcode decoder: operation kind, addressing mode and cycle count
`timescale 1ns/1ns
`default_nettype none
`include "trap_core_map.svh"
module trap_opcode_decode (
  input wire logic [7:0] i_opcode,
  output trap_core_pkg::decode_t o_dec
);
  // pure decode, no state
  always_comb begin
    o_dec.mode = trap_core_pkg::inherent_mode;
    o_dec.op = trap_core_pkg::other_op;
    o_dec.src_index = i_opcode[4];
    o_dec.cycles = 4'h0;
    if (i_opcode == `OP_TRAP) begin
      o_dec.op = trap_core_pkg::software_trap_op;
      o_dec.cycles = `CYC_TRAP;
    end else if (i_opcode == `OP_A2X) begin
      o_dec.op = trap_core_pkg::acc_to_index_op;
      o_dec.cycles = `CYC_XFER;
    end else if (i_opcode == `OP_X2A) begin
      o_dec.op = trap_core_pkg::index_to_acc_op;
      o_dec.cycles = `CYC_XFER;
    end else if (i_opcode == `OP_WAIT) begin
      o_dec.op = trap_core_pkg::wait_op;
      o_dec.cycles = `CYC_WAIT;
    end else if (i_opcode[3:0] == 4'hd && i_opcode[7:4] >= 4'h3 && i_opcode[7:4] <= 4'h7) begin
      // test column: mode from the high nibble
      o_dec.op = trap_core_pkg::test_operand_op;
      unique case (i_opcode[7:4])
        4'h3: begin
          o_dec.mode = trap_core_pkg::direct_mode;
          o_dec.cycles = `CYC_TEST_DIR;
        end
        4'h4, 4'h5: begin
          o_dec.cycles = `CYC_TEST_REG;
        end
        4'h6: begin
          o_dec.mode = trap_core_pkg::indexed_short_offset_mode;
          o_dec.cycles = `CYC_TEST_SHORT;
        end
        default: begin
          o_dec.mode = trap_core_pkg::indexed_no_offset_mode;
          o_dec.cycles = `CYC_TEST_NOOFS;
        end
      endcase
    end else if (i_opcode[7:4] >= 4'hb) begin
      // register/memory columns: only operand fetch is carried out here
      unique case (i_opcode[7:4])
        4'hb: o_dec.mode = trap_core_pkg::direct_mode;
        4'hc: o_dec.mode = trap_core_pkg::extended_mode;
        4'hd: o_dec.mode = trap_core_pkg::indexed_long_offset_mode;
        4'he: o_dec.mode = trap_core_pkg::indexed_short_offset_mode;
        default: o_dec.mode = trap_core_pkg::indexed_no_offset_mode;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the trap, transfer, test and wait core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ****************************************
  // stimulus, memory and scoreboard state
  // ****************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic irq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic halted;
  trap_core_pkg::mem_req_t mreq;
  logic [7:0] mrd;
  logic [7:0] mem [0:65535]; // async-read memory, unset bytes stay unknown
  logic [7:0] prog [10] = '{8'h97, 8'h9f, 8'h4d, 8'h5d, 8'h7d, 8'h6d, 8'h10, 8'h3d, 8'h40, 8'h83};
  logic [64:0] aq [$]; // expected reads {mask, error, data}
  logic [23:0] mq [$]; // expected stack writes {address, byte}
  logic [7:0] opnd;
  logic [7:0] fl; // flags expected at the trap
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_push = 0;
  int t_halt = 0;
  integer seed = 32'ha2f4;

  assign mrd = mem[mreq.addr]; // memory must answer in the same cycle

  trap_core DUT (.i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_mem(mreq), .i_mem_rdata(mrd),
    .i_irq(irq), .o_cpu_halted(halted));

  // free-running 20 MHz clock
  always #25 clk = ~clk;

  // ****************************************
  // bus tasks and comparisons
  // ****************************************
  task automatic fail(input string m);
    miscompares++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic e = 1'b0);
    aq.push_back({m, e, d});
    apb(1'b0, a, 32'h0);
  endtask

  // five stack bytes: pc low, pc high, index, accumulator, flags
  task automatic push5(input logic [7:0] ptr, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] f);
    logic [7:0] b [5];
    b = '{lo, hi, 8'h00, 8'h00, f};
    for (int i = 0; i < 5; i++) mq.push_back({8'h00, ptr - 8'(i), b[i]});
  endtask

  task automatic chk_apb(input logic [32:0] got);
    logic [64:0] e;
    n_tests++;
    if (aq.size() == 0) fail("unexpected apb read");
    else begin
      e = aq.pop_front();
      if (((got ^ e[32:0]) & {1'b1, e[64:33]}) !== 33'h0) fail("apb read mismatch");
    end
  endtask

  task automatic chk_mem(input logic [23:0] got);
    n_tests++;
    if (mq.size() == 0) fail("unexpected memory write");
    else if (got !== mq.pop_front()) fail("stack write mismatch");
  endtask

  // watcher samples mid-cycle, where outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk_apb({pslverr, prdata});
    if (mreq.we === 1'b1) begin
      mem[mreq.addr] = mreq.wdata;
      if (t_push == 0) t_push = cyc;
      chk_mem({mreq.addr, mreq.wdata}); // stacking order
    end
    if (halted === 1'b1 && t_halt == 0) t_halt = cyc;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    #200000;
    fail("timeout");
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    foreach (prog[i]) mem[i] = prog[i]; // transfers, tests, short offset
    mem[16'h0010] = 8'($random(seed));
    mem[16'h0040] = 8'($random(seed));
    mem[16'h0100] = 8'h8f;
    mem[16'hfffc] = 8'h01;
    mem[16'hfffd] = 8'h00;
    mem[16'hfffa] = 8'h02;
    mem[16'hfffb] = 8'h00;
    mem[16'h0200] = 8'hc6;
    mem[16'h0201] = 8'h12;
    mem[16'h0202] = 8'h34;
    mem[16'h0203] = 8'hd6; // long offset column, run after resume
    mem[16'h0204] = 8'h56;
    mem[16'h0205] = 8'h78;
    opnd = mem[16'h0040];
    fl = {3'b111, 1'b0, 1'b1, opnd[7], opnd == 8'h00, 1'b0}; // last test sets n, z
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h008, {8'he8, 8'hff, 16'h0}, '1); // reset register values
    push5(8'hff, 8'h0a, 8'h00, fl); // trap stacking
    apb(1'b1, 12'h000, 32'h1);
    for (int i = 0; i < 300 && halted !== 1'b1; i++) @(posedge clk);
    n_tests++;
    if (t_halt - t_push != 11) fail("trap or wait cycle count"); // timing
    rd(12'h004, 32'h5, '1); // waiting status
    apb(1'b1, 12'h008, $random(seed));
    apb(1'b1, 12'h010, $random(seed));
    rd(12'h008, {fl & 8'hf7, 8'hfa, 16'h0}, '1); // mask cleared
    rd(12'h010, 32'h0, '1, 1'b1);
    rd(12'h000, 32'h1, '1);
    push5(8'hfa, 8'h01, 8'h01, fl & 8'hf7); // wake stacking
    @(posedge clk);
    irq <= 1'b1;
    for (int i = 0; i < 50 && halted === 1'b1; i++) @(posedge clk);
    irq <= 1'b0;
    repeat (20) @(posedge clk);
    rd(12'h004, 32'h6, '1); // halted on unsupported opcode
    rd(12'h008, {fl, 8'hf5, 16'h0}, '1); // mask set again
    rd(12'h00c, 32'h12340203, '1); // address high then low, pc past both
    apb(1'b1, 12'h000, 32'h3); // run kept, resume from halt
    repeat (8) @(posedge clk);
    rd(12'h004, 32'h6, '1); // halted after long offset fetch
    rd(12'h00c, 32'h56780206, '1); // offset high then low, index zero
    @(posedge clk);
    n_tests++;
    if (aq.size() + mq.size() != 0) fail("expected results never appeared");
    conclude();
  end
endmodule
`default_nettype wire
